// file: cmm_byte_reg.sv
// one 8-bit register with load enable and reset value
`timescale 1ns/10ps
`default_nettype none

module cmm_byte_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       we,
  input  wire logic [7:0] d,
  output logic      [7:0] q
);

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= RESET_VAL;
    end else if (we) begin
      q <= d;
    end
  end

endmodule

`default_nettype wire

// file: cmm_core_map.sv
// internal data memory map and core special function registers
//
// What this block does
// - push increments stack pointer, then writes
// - stack pointer resets to 07h
// - pointer bytes separate; pair increment carries into page
// - data pointer drives code and data addresses
// - low 32 bytes are four register banks
// - next 16 bytes bit addressable, bits 00h-7fh
// - status bits 4:3 select active bank
// - status word at d0h, reset 00h, bitwise
// - status word flag positions, two user flags
// - power control at 87h, reset 00h, bytewise
// - power control bit meanings, 6:5 reserved
// - upper 128 direct addresses are special registers
// - only x0h/x8h special registers are bit addressable
// - unmapped special addresses hold no register
// - program and data spaces kept separate
// - aux register is second mul/div operand
// - port 1 digital only after writing zero
// - external access pin picks fetch source
`timescale 1ns/10ps
`default_nettype none
`include "cmm_defs.svh"

module cmm_core_map (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire cmm_pkg::cmm_req_s req,
  input  wire cmm_pkg::cmm_flag_s flags,
  output logic                   ready,
  output logic                   rsp_valid,
  output logic [7:0]             rsp_data,
  output logic                   rsp_bit,
  output logic [1:0]             bank_sel,
  output cmm_pkg::cmm_ctrl_s     ctrl,
  output logic [23:0]            data_pointer,
  output logic [7:0]             stack_pointer,
  output logic [7:0]             accumulator,
  output logic [7:0]             aux_operand,
  output logic                   carry_flag,
  output logic [7:0]             port1_digital_en,
  input  wire logic              external_fetch_select,
  input  wire logic [15:0]       fetch_addr,
  output logic                   fetch_internal
);
  import cmm_pkg::*;

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  cmm_state_e  state;              // bit write sequencer
  logic        take;               // request accepted this cycle
  logic        ram_we;             // ram write strobe
  logic [7:0]  ram_addr;           // ram address
  logic [7:0]  ram_wd;             // ram write data
  logic [7:0]  ram_rd;             // ram read data, registered
  logic        sfr_we;             // special register write strobe
  logic [7:0]  sfr_addr;           // special register address
  logic [7:0]  sfr_wd;             // special register write data
  logic [7:0]  sfr_rd;             // special register read value
  logic        sp_we;              // push or pop moves the stack
  logic [7:0]  next_sp;            // stack pointer after push/pop
  logic        ptr_inc;            // increment the pointer chain
  logic [23:0] next_ptr;           // incremented pointer
  logic        is_rd;              // request returns data
  logic        rd_ram;             // read data comes from ram
  logic [7:0]  bit_byte;           // byte holding an addressed bit
  logic        merge_go;           // ram bit write needs a merge
  logic [7:0]  merged;             // ram byte with one bit replaced
  logic [7:0]  mg_addr;            // merge target byte
  logic [2:0]  mg_idx;             // merge bit index
  logic        mg_val;             // merge bit value
  logic        rsel_ram;           // answer taken from ram
  logic [2:0]  bitsel;             // answer bit index
  logic [7:0]  sfr_rd_q;           // captured special register value
  logic [7:0]  stat;               // stored status bits 7..1
  logic [7:0]  pwr;                // power control storage
  logic [7:0]  p1;                 // port 1 latch
  logic [7:0]  ptr_lo;             // pointer_low_byte
  logic [7:0]  ptr_hi;             // pointer_high_byte
  logic [7:0]  ptr_pg;             // pointer_page_byte
  logic [7:0]  stat_view;          // status word with live parity
  logic        fsel_s1;            // pin synchroniser, first stage
  logic        fsel_s2;            // pin synchroniser, second stage

  // ----------------------------------------------------------------------
  // handshake
  // ----------------------------------------------------------------------
  // a ram bit write costs two cycles, so hold off the core meanwhile
  assign ready = (state == ST_IDLE);
  assign take  = ready && (req.op != OP_NONE);

  // ----------------------------------------------------------------------
  // bit address to byte address
  // ----------------------------------------------------------------------
  // low bit addresses land in ram 20h..2fh, high ones in x0h/x8h regs
  always_comb begin
    if (req.addr[7]) begin
      bit_byte = {req.addr[7:3], 3'b000};
    end else begin
      bit_byte = {`CMM_BIT_BASE_HI, req.addr[6:3]};
    end
  end

  // ----------------------------------------------------------------------
  // status word view, parity follows the accumulator
  // ----------------------------------------------------------------------
  assign stat_view = {stat[7:1], ^accumulator};

  // ----------------------------------------------------------------------
  // special register read mux
  // ----------------------------------------------------------------------
  always_comb begin
    unique case (sfr_addr)
      `CMM_ADDR_SP:     sfr_rd = stack_pointer;
      `CMM_ADDR_PTR_LO: sfr_rd = ptr_lo;
      `CMM_ADDR_PTR_HI: sfr_rd = ptr_hi;
      `CMM_ADDR_PTR_PG: sfr_rd = ptr_pg;
      `CMM_ADDR_PWR:    sfr_rd = pwr & `CMM_PWR_MASK;
      `CMM_ADDR_P1:     sfr_rd = p1;
      `CMM_ADDR_STAT:   sfr_rd = stat_view;
      `CMM_ADDR_ACCU:   sfr_rd = accumulator;
      `CMM_ADDR_B:      sfr_rd = aux_operand;
      // empty locations have no storage; a fixed zero is returned
      default:        sfr_rd = `CMM_UNMAPPED;
    endcase
  end

  // ----------------------------------------------------------------------
  // ram byte for the second half of a bit write
  // ----------------------------------------------------------------------
  always_comb begin
    merged         = ram_rd;
    merged[mg_idx] = mg_val;
  end

  // ----------------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------------
  always_comb begin
    ram_addr = req.addr;
    ram_we   = 1'b0;
    ram_wd   = req.wdata;
    sfr_we   = 1'b0;
    sfr_addr = req.addr;
    sfr_wd   = req.wdata;
    sp_we    = 1'b0;
    next_sp  = stack_pointer;
    ptr_inc  = 1'b0;
    is_rd    = 1'b0;
    rd_ram   = 1'b0;
    merge_go = 1'b0;
    if (state == ST_MERGE) begin
      // write back the byte read last cycle
      ram_addr = mg_addr;
      ram_we   = 1'b1;
      ram_wd   = merged;
    end else if (take) begin
      unique case (req.op)
        OP_DIR_RD: begin
          // direct upper half means special registers, not ram
          is_rd  = 1'b1;
          rd_ram = !req.addr[7];
        end
        OP_DIR_WR: begin
          if (req.addr[7]) begin
            sfr_we = 1'b1;
          end else begin
            ram_we = 1'b1;
          end
        end
        OP_IND_RD: begin
          // indirect reaches all 256 ram bytes, never registers
          is_rd  = 1'b1;
          rd_ram = 1'b1;
        end
        OP_IND_WR: begin
          ram_we = 1'b1;
        end
        OP_BIT_RD: begin
          is_rd    = 1'b1;
          ram_addr = bit_byte;
          sfr_addr = bit_byte;
          rd_ram   = !req.addr[7];
        end
        OP_BIT_WR: begin
          if (req.addr[7]) begin
            // registers are flops, so merge in a single cycle
            sfr_addr                = bit_byte;
            sfr_wd                  = sfr_rd;
            sfr_wd[req.addr[2:0]]   = req.bit_val;
            sfr_we                  = 1'b1;
          end else begin
            ram_addr = bit_byte;
            merge_go = 1'b1;
          end
        end
        OP_PUSH: begin
          // pointer moves up first, data goes to the new slot
          next_sp  = stack_pointer + 8'h01;
          sp_we    = 1'b1;
          ram_addr = next_sp;
          ram_we   = 1'b1;
        end
        OP_POP: begin
          is_rd    = 1'b1;
          rd_ram   = 1'b1;
          ram_addr = stack_pointer;
          next_sp  = stack_pointer - 8'h01;
          sp_we    = 1'b1;
        end
        OP_WREG_RD: begin
          ram_addr = {3'b000, bank_sel, req.addr[2:0]};
          is_rd    = 1'b1;
          rd_ram   = 1'b1;
        end
        OP_WREG_WR: begin
          ram_addr = {3'b000, bank_sel, req.addr[2:0]};
          ram_we   = 1'b1;
        end
        OP_PTR_INC: begin
          ptr_inc = 1'b1;
        end
        OP_NONE: begin
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // bit write sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state   <= ST_IDLE;
      mg_addr <= 8'h00;
      mg_idx  <= 3'h0;
      mg_val  <= 1'b0;
    end else if (state == ST_MERGE) begin
      state <= ST_IDLE;
    end else if (merge_go) begin
      state   <= ST_MERGE;
      mg_addr <= bit_byte;
      mg_idx  <= req.addr[2:0];
      mg_val  <= req.bit_val;
    end
  end

  // ----------------------------------------------------------------------
  // read answer, one cycle after the request
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_valid <= 1'b0;
      rsel_ram  <= 1'b0;
      bitsel    <= 3'h0;
      sfr_rd_q  <= 8'h00;
    end else begin
      rsp_valid <= is_rd;
      if (is_rd) begin
        rsel_ram <= rd_ram;
        bitsel   <= req.addr[2:0];
        sfr_rd_q <= sfr_rd;
      end
    end
  end

  assign rsp_data = rsel_ram ? ram_rd : sfr_rd_q;
  assign rsp_bit  = rsp_data[bitsel];

  // ----------------------------------------------------------------------
  // internal ram
  // ----------------------------------------------------------------------
  cmm_iram u_iram (
    .clk    (clk),
    .arst_n (arst_n),
    .we     (ram_we),
    .addr   (ram_addr),
    .wd     (ram_wd),
    .rd     (ram_rd)
  );

  // ----------------------------------------------------------------------
  // stack pointer
  // ----------------------------------------------------------------------
  cmm_byte_reg #(.RESET_VAL(`CMM_RST_SP)) u_sp (
    .clk    (clk),
    .arst_n (arst_n),
    .we     (sp_we || (sfr_we && sfr_addr == `CMM_ADDR_SP)),
    .d      (sp_we ? next_sp : sfr_wd),
    .q      (stack_pointer)
  );

  // ----------------------------------------------------------------------
  // data pointer chain, increment ripples into the page byte
  // ----------------------------------------------------------------------
  assign next_ptr = {ptr_pg, ptr_hi, ptr_lo} + 24'h000001;

  cmm_byte_reg #(.RESET_VAL(`CMM_RST_ZERO)) u_ptr_lo (
    .clk    (clk),
    .arst_n (arst_n),
    .we     (ptr_inc || (sfr_we && sfr_addr == `CMM_ADDR_PTR_LO)),
    .d      (ptr_inc ? next_ptr[7:0] : sfr_wd),
    .q      (ptr_lo)
  );

  cmm_byte_reg #(.RESET_VAL(`CMM_RST_ZERO)) u_ptr_hi (
    .clk    (clk),
    .arst_n (arst_n),
    .we     (ptr_inc || (sfr_we && sfr_addr == `CMM_ADDR_PTR_HI)),
    .d      (ptr_inc ? next_ptr[15:8] : sfr_wd),
    .q      (ptr_hi)
  );

  cmm_byte_reg #(.RESET_VAL(`CMM_RST_ZERO)) u_ptr_pg (
    .clk    (clk),
    .arst_n (arst_n),
    .we     (ptr_inc || (sfr_we && sfr_addr == `CMM_ADDR_PTR_PG)),
    .d      (ptr_inc ? next_ptr[23:16] : sfr_wd),
    .q      (ptr_pg)
  );

  assign data_pointer = {ptr_pg, ptr_hi, ptr_lo};

  // ----------------------------------------------------------------------
  // accumulator and aux operand
  // ----------------------------------------------------------------------
  cmm_byte_reg #(.RESET_VAL(`CMM_RST_ZERO)) u_accu (
    .clk    (clk),
    .arst_n (arst_n),
    .we     (sfr_we && sfr_addr == `CMM_ADDR_ACCU),
    .d      (sfr_wd),
    .q      (accumulator)
  );

  // exported straight to the multiplier/divider as second operand
  cmm_byte_reg #(.RESET_VAL(`CMM_RST_ZERO)) u_b (
    .clk    (clk),
    .arst_n (arst_n),
    .we     (sfr_we && sfr_addr == `CMM_ADDR_B),
    .d      (sfr_wd),
    .q      (aux_operand)
  );

  // ----------------------------------------------------------------------
  // port 1 latch, ones keep the pins analog
  // ----------------------------------------------------------------------
  cmm_byte_reg #(.RESET_VAL(`CMM_RST_P1)) u_p1 (
    .clk    (clk),
    .arst_n (arst_n),
    .we     (sfr_we && sfr_addr == `CMM_ADDR_P1),
    .d      (sfr_wd),
    .q      (p1)
  );

  assign port1_digital_en = ~p1;

  // ----------------------------------------------------------------------
  // status word, alu flag updates win over a software write
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stat <= `CMM_RST_STAT;
    end else begin
      if (sfr_we && sfr_addr == `CMM_ADDR_STAT) begin
        stat <= {sfr_wd[7:1], 1'b0};
      end
      // later assignments take priority: hardware beats software
      if (flags.we_carry) begin
        stat[`CMM_STAT_CARRY] <= flags.carry;
      end
      if (flags.we_half) begin
        stat[`CMM_STAT_HALF] <= flags.half;
      end
      if (flags.we_ovf) begin
        stat[`CMM_STAT_OVF] <= flags.ovf;
      end
    end
  end

  assign bank_sel   = stat[`CMM_STAT_BANK_HI:`CMM_STAT_BANK_LO];
  assign carry_flag = stat[`CMM_STAT_CARRY];

  // ----------------------------------------------------------------------
  // power control, byte writes only, reserved bits never stored
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwr <= `CMM_RST_PWR;
    end else if (sfr_we && sfr_addr == `CMM_ADDR_PWR) begin
      // a bit write would come through the x0h/x8h path, never here
      pwr <= sfr_wd & `CMM_PWR_MASK;
    end
  end

  assign ctrl.baud_doubler         = pwr[`CMM_PWR_BAUD];
  assign ctrl.latch_strobe_disable = pwr[`CMM_PWR_LATCH];
  assign ctrl.power_down_enable    = pwr[`CMM_PWR_DOWN];
  assign ctrl.idle_enable          = pwr[`CMM_PWR_IDLE];

  // ----------------------------------------------------------------------
  // fetch source select, pin synchronised first
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fsel_s1 <= 1'b0;
      fsel_s2 <= 1'b0;
    end else begin
      fsel_s1 <= external_fetch_select;
      fsel_s2 <= fsel_s1;
    end
  end

  // code space is a separate bus; this map never serves fetches
  assign fetch_internal = fsel_s2 &&
                          (fetch_addr <= `CMM_INT_CODE_TOP);

endmodule

`default_nettype wire

// file: cmm_core_map_properties.sv
// concurrent checks on the core memory map ports
`timescale 1ns/10ps
`default_nettype none

module cmm_core_map_props (
  input wire logic               clk,
  input wire logic               arst_n,
  input wire cmm_pkg::cmm_req_s  req,
  input wire cmm_pkg::cmm_flag_s flags,
  input wire logic               ready,
  input wire logic               rsp_valid,
  input wire logic [23:0]        data_pointer,
  input wire logic [7:0]         stack_pointer,
  input wire logic               carry_flag,
  input wire cmm_pkg::cmm_ctrl_s ctrl,
  input wire logic               external_fetch_select,
  input wire logic [15:0]        fetch_addr,
  input wire logic               fetch_internal
);
  import cmm_pkg::*;
  // a request counts only when the port is ready
  wire logic taken = ready && (req.op != OP_NONE);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_push_inc: assert property (taken && req.op == OP_PUSH
    |=> stack_pointer == $past(stack_pointer) + 8'h01) else $error("push sp");
  a_pop_dec: assert property (taken && req.op == OP_POP
    |=> stack_pointer == $past(stack_pointer) - 8'h01) else $error("pop sp");
  a_read_answer: assert property (taken && req.op inside {OP_DIR_RD,
    OP_IND_RD, OP_BIT_RD, OP_POP, OP_WREG_RD} |=> rsp_valid)
    else $error("read gave no answer");
  a_pair_carry: assert property (taken && req.op == OP_PTR_INC
    |=> data_pointer == $past(data_pointer) + 24'h1)
    else $error("pointer inc");
  a_bit_dead: assert property (taken && req.op == OP_BIT_WR
    && !req.addr[7] |=> !ready ##1 ready) else $error("bit write cycle");
  a_carry_set: assert property (flags.we_carry
    |=> carry_flag == $past(flags.carry)) else $error("carry update");
  a_idle_bit: assert property (taken && req.op == OP_DIR_WR
    && req.addr == 8'h87 |=> ctrl.idle_enable == $past(req.wdata[0]))
    else $error("idle enable");
  a_fetch_top: assert property (fetch_addr > 16'h1fff
    |-> !fetch_internal) else $error("fetch above internal top");
  a_fetch_ext: assert property (!external_fetch_select[*3]
    |-> !fetch_internal) else $error("fetch with pin low");
endmodule

bind cmm_core_map cmm_core_map_props u_cmm_core_map_props (.clk, .arst_n,
  .req, .flags, .ready, .rsp_valid, .data_pointer, .stack_pointer,
  .carry_flag, .ctrl, .external_fetch_select, .fetch_addr, .fetch_internal);
`default_nettype wire

// file: cmm_core_model.sv
// execution logic model that issues accesses to the memory map
`timescale 1ns/10ps
`default_nettype none

module cmm_core_model (
  input  wire logic         clk,
  input  wire logic         ready,
  input  wire logic         rsp_valid,
  input  wire logic [7:0]   rsp_data,
  output cmm_pkg::cmm_req_s req,
  output cmm_pkg::cmm_flag_s flags,
  output logic              external_fetch_select,
  output logic [15:0]       fetch_addr
);
  import cmm_pkg::*;
  initial begin
    req = '0;
    flags = '0;
    external_fetch_select = 1'b0;
    fetch_addr = 16'h0000;
  end
  // held until taken; caller issues the next one or an idle op
  task automatic xfer(input cmm_op_e o, input logic [7:0] a, d,
                      input logic b, output logic [7:0] q);
    req = '{o, a, d, b};
    while (ready !== 1'b1) @(posedge clk) #1;
    @(posedge clk) #1;
    q = rsp_valid ? rsp_data : 8'hxx; // answer stands one cycle only
  endtask
  // one-cycle carry strobe from the alu
  task automatic pulse_carry(input logic c);
    flags = '{1'b1, c, 1'b0, 1'b0, 1'b0, 1'b0};
    @(posedge clk) #1;
    flags = '0;
  endtask
  // pin passes two flops, so let three edges go by
  task automatic set_fetch(input logic e, input logic [15:0] a);
    external_fetch_select = e;
    fetch_addr = a;
    repeat (3) @(posedge clk) #1;
  endtask
endmodule
`default_nettype wire

// file: cmm_defs.svh
// address map, field positions and reset values of the core memory map
`ifndef CMM_DEFS_SVH
`define CMM_DEFS_SVH

// ----------------------------------------------------------------------
// special function register addresses
// ----------------------------------------------------------------------
`define CMM_ADDR_SP     8'h81
`define CMM_ADDR_PTR_LO 8'h82
`define CMM_ADDR_PTR_HI 8'h83
`define CMM_ADDR_PTR_PG 8'h84
`define CMM_ADDR_PWR    8'h87
`define CMM_ADDR_P1     8'h90
`define CMM_ADDR_STAT   8'hd0
`define CMM_ADDR_ACCU   8'he0
`define CMM_ADDR_B      8'hf0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CMM_RST_ZERO    8'h00
`define CMM_RST_SP      8'h07
`define CMM_RST_STAT    8'h00
`define CMM_RST_PWR     8'h00
`define CMM_RST_P1      8'hff
`define CMM_UNMAPPED    8'h00

// ----------------------------------------------------------------------
// status word fields
// ----------------------------------------------------------------------
`define CMM_STAT_CARRY   7
`define CMM_STAT_HALF    6
`define CMM_STAT_OVF     2
`define CMM_STAT_BANK_HI 4
`define CMM_STAT_BANK_LO 3

// ----------------------------------------------------------------------
// power control fields and writable mask (bits 6 and 5 reserved)
// ----------------------------------------------------------------------
`define CMM_PWR_BAUD    7
`define CMM_PWR_LATCH   4
`define CMM_PWR_DOWN    1
`define CMM_PWR_IDLE    0
`define CMM_PWR_MASK    8'h9f

// ----------------------------------------------------------------------
// memory layout
// ----------------------------------------------------------------------
`define CMM_BIT_BASE_HI 4'h2
`define CMM_INT_CODE_TOP 16'h1fff

`endif

// file: cmm_iram.sv
// 256-byte internal data ram, registered read port
`timescale 1ns/10ps
`default_nettype none

module cmm_iram (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       we,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wd,
  output logic      [7:0] rd
);

  logic [7:0] mem [256];  // array has no reset, like real ram

  // ----------------------------------------------------------------------
  // write port
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wd;
    end
  end

  // ----------------------------------------------------------------------
  // read data register, one cycle after address
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd <= 8'h00;
    end else if (!we) begin
      rd <= mem[addr];
    end
  end

endmodule

`default_nettype wire

// file: cmm_pkg.sv
// types shared by the core memory map block
package cmm_pkg;

  // ----------------------------------------------------------------------
  // access kinds issued by the execution logic
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE     = 4'h0,
    OP_DIR_RD   = 4'h1,
    OP_DIR_WR   = 4'h2,
    OP_IND_RD   = 4'h3,
    OP_IND_WR   = 4'h4,
    OP_BIT_RD   = 4'h5,
    OP_BIT_WR   = 4'h6,
    OP_PUSH     = 4'h7,
    OP_POP      = 4'h8,
    OP_WREG_RD  = 4'h9,
    OP_WREG_WR  = 4'ha,
    OP_PTR_INC  = 4'hb
  } cmm_op_e;

  // bit write sequencer states
  typedef enum logic {
    ST_IDLE  = 1'b0,
    ST_MERGE = 1'b1
  } cmm_state_e;

  // one access request
  typedef struct packed {
    cmm_op_e    op;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       bit_val;
  } cmm_req_s;

  // arithmetic flag updates from the alu
  typedef struct packed {
    logic we_carry;
    logic carry;
    logic we_half;
    logic half;
    logic we_ovf;
    logic ovf;
  } cmm_flag_s;

  // power control outputs
  typedef struct packed {
    logic baud_doubler;
    logic latch_strobe_disable;
    logic power_down_enable;
    logic idle_enable;
  } cmm_ctrl_s;

endpackage

// file: tb_cmm_core_map.sv
// self-checking bench for the core memory map
`timescale 1ns/10ps
`default_nettype none

module tb_cmm_core_map;
  import cmm_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, ready, rsp_valid, rsp_bit, carry_flag;
  logic external_fetch_select, fetch_internal;
  logic [7:0] rsp_data, stack_pointer, accumulator, aux_operand, q;
  logic [7:0] port1_digital_en;
  logic [1:0] bank_sel;
  logic [15:0] fetch_addr;
  logic [23:0] data_pointer;
  cmm_req_s req;
  cmm_flag_s flags;
  cmm_ctrl_s ctrl;
  int failures = 0, n_compared = 0, cycles = 0;
  always #20 clk = ~clk;
  cmm_core_map u_cmm_core_map (.clk, .arst_n, .req, .flags, .ready,
    .rsp_valid, .rsp_data, .rsp_bit, .bank_sel, .ctrl, .data_pointer,
    .stack_pointer, .accumulator, .aux_operand, .carry_flag,
    .port1_digital_en, .external_fetch_select, .fetch_addr, .fetch_internal);
  cmm_core_model u_cmm_core_model (.clk, .ready, .rsp_valid, .rsp_data,
    .req, .flags, .external_fetch_select, .fetch_addr);
  task automatic end_of_test;
    if (failures == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard: the whole run needs well under a hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      end_of_test;
    end
  end
  task automatic chk(input logic [23:0] g, e);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic op(input cmm_op_e o, input logic [7:0] a, d = 8'h00,
                    input logic b = 1'b0);
    u_cmm_core_model.xfer(o, a, d, b, q);
  endtask
  task automatic t_reset;
    chk(24'(stack_pointer), 24'h07);
    op(OP_DIR_RD, 8'hd0); chk(24'(q), 24'h00);
    op(OP_DIR_RD, 8'h87); chk(24'(q), 24'h00);
    chk(24'(port1_digital_en), 24'h00);
  endtask
  task automatic t_stack;
    op(OP_PUSH, 8'h00, 8'ha5); chk(24'(stack_pointer), 24'h08);
    op(OP_IND_RD, 8'h08); chk(24'(q), 24'ha5);
    op(OP_POP, 8'h00); chk(24'(q), 24'ha5);
    chk(24'(stack_pointer), 24'h07);
  endtask
  task automatic t_pointer;
    op(OP_DIR_WR, 8'h82, 8'hff);
    op(OP_DIR_WR, 8'h83, 8'hff);
    op(OP_DIR_WR, 8'h84, 8'h12);
    op(OP_PTR_INC, 8'h00); chk(data_pointer, 24'h130000);
    op(OP_DIR_RD, 8'h84); chk(24'(q), 24'h13);
  endtask
  task automatic t_banks;
    for (int b = 0; b < 4; b++) begin
      op(OP_DIR_WR, 8'hd0, 8'(b << 3)); chk(24'(bank_sel), 24'(b));
      op(OP_WREG_WR, 8'h07, 8'(b) + 8'h40);
      op(OP_IND_RD, 8'(b * 8 + 7)); chk(24'(q), 24'(b + 64));
    end
  endtask
  task automatic t_bits;
    op(OP_DIR_WR, 8'h21, 8'h00);
    op(OP_BIT_WR, 8'h0b, 8'h00, 1'b1);
    op(OP_IND_RD, 8'h21); chk(24'(q), 24'h08);
    op(OP_BIT_RD, 8'h0b); chk(24'(rsp_bit), 24'h1);
    op(OP_BIT_RD, 8'h0a); chk(24'(rsp_bit), 24'h0);
    op(OP_BIT_WR, 8'hd5, 8'h00, 1'b1);
    op(OP_DIR_RD, 8'hd0); chk(24'(q), 24'h38);
    op(OP_BIT_RD, 8'hd5); chk(24'(rsp_bit), 24'h1);
  endtask
  task automatic t_sfr;
    op(OP_DIR_WR, 8'h87, 8'hff);
    op(OP_DIR_RD, 8'h87); chk(24'(q), 24'h9f);
    chk(24'(ctrl), 24'hf);
    op(OP_DIR_WR, 8'h85, 8'h55);
    op(OP_DIR_RD, 8'h85); chk(24'(q), 24'h00);
    op(OP_DIR_WR, 8'he0, 8'h03);
    op(OP_DIR_WR, 8'hf0, 8'h06); chk(24'(aux_operand), 24'h06);
    chk(24'(accumulator), 24'h03);
  endtask
  task automatic t_upper;
    op(OP_IND_WR, 8'h90, 8'h77);
    op(OP_DIR_RD, 8'h90); chk(24'(q), 24'hff);
    op(OP_IND_RD, 8'h90); chk(24'(q), 24'h77);
    op(OP_DIR_WR, 8'h90, 8'hfe);
    op(OP_NONE, 8'h00); chk(24'(port1_digital_en), 24'h01);
  endtask
  task automatic t_pins;
    u_cmm_core_model.pulse_carry(1'b1); chk(24'(carry_flag), 24'h1);
    u_cmm_core_model.set_fetch(1'b1, 16'h1fff);
    chk(24'(fetch_internal), 24'h1);
    u_cmm_core_model.set_fetch(1'b1, 16'h2000);
    chk(24'(fetch_internal), 24'h0);
    u_cmm_core_model.set_fetch(1'b0, 16'h0000);
    chk(24'(fetch_internal), 24'h0);
  endtask
  // main sequence: reset for six cycles, then each scenario in turn
  initial begin
    repeat (6) @(posedge clk);
    #1 arst_n = 1'b1;
    t_reset;
    t_stack;
    t_pointer;
    t_banks;
    t_bits;
    t_sfr;
    t_upper;
    t_pins;
    end_of_test;
  end
endmodule
`default_nettype wire
